// ===== logic/lpc_pkg.sv
// lpc_pkg: constants, carrier types and shared arithmetic of the speech front end
// assumes one 100 MHz clock and Q15 / Q13 fixed point in all files
package lpc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int PCM_W = 13;
  localparam int FRAME_LEN = 160;
  localparam int ORDER = 8;
  localparam int NUM_LAGS = 9;
  localparam int CODE_BITS = 36;
  localparam int DELAY_MAX_MS = 30;
  localparam int ACF_CYCLES = 1404;
  localparam int DIV_STEPS = 15;
  localparam logic [7:0] LAST_IDX = 8'h9F;
  localparam logic [7:0] SEG1_START = 8'h0D;
  localparam logic [7:0] SEG2_START = 8'h1B;
  localparam logic [7:0] SEG3_START = 8'h28;
  localparam logic [15:0] ALPHA_Q15 = 16'h7FDF;
  localparam logic [15:0] BETA_Q15 = 16'h6E14;
  localparam logic [15:0] RC_KNEE1 = 16'h5666;
  localparam logic [15:0] RC_KNEE2 = 16'h799A;
  localparam logic [15:0] RC_OFS1 = 16'h2B33;
  localparam logic [15:0] RC_OFS2 = 16'h6600;
  localparam logic [17:0] LAR_0675 = 18'h0159A;
  localparam logic [17:0] LAR_KNEE2 = 18'h02733;
  localparam logic [17:0] LAR_MAX = 18'h03400;
  localparam logic [17:0] LAR_OFS2 = 18'h0CC00;
  localparam logic [34:0] HALF_Q13 = 35'h000001000;
  localparam logic [15:0] A_Q8 [ORDER] = '{16'h1400, 16'h1400, 16'h1400, 16'h1400,
                                            16'h0DA3, 16'h0F00, 16'h0855, 16'h08D3};
  localparam logic signed [17:0] B_Q13 [ORDER] = '{18'h00000, 18'h00000, 18'h08000, 18'h36000,
                                                   18'h005E3, 18'h39000, 18'h3EAB0, 18'h3B87B};
  localparam logic [15:0] INV_A_Q16 [ORDER] = '{16'h0CCD, 16'h0CCD, 16'h0CCD, 16'h0CCD,
                                                 16'h12C6, 16'h1111, 16'h1EB8, 16'h1D03};
  localparam int CODE_W [ORDER] = '{6, 6, 5, 5, 4, 4, 3, 3};
  localparam int CODE_POS [ORDER] = '{0, 6, 12, 17, 22, 26, 30, 33};

  typedef struct packed {
    logic signed [PCM_W-1:0] value;
  } pcm_t;

  typedef struct packed {
    logic [7:0] index;
    logic [1:0] segment;
    logic signed [15:0] sample;
    logic [ORDER-1:0][15:0] rc;
  } feed_t;

  typedef enum {S_COLLECT, S_ACF, S_NORM, S_SCHUR, S_DIV, S_RC, S_UPD, S_LAR, S_PREP, S_READ} state_t;

  function automatic logic signed [15:0] sat16(input logic signed [19:0] x);
    if (x > 20'sh07FFF)
      return 16'sh7FFF;
    if (x < -20'sh08000)
      return 16'sh8000;
    return 16'(x);
  endfunction

  // rounded Q15 product
  function automatic logic signed [15:0] mulr(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b) + 32'sh00004000;
    return sat16(20'(p >>> 15));
  endfunction

  function automatic logic signed [15:0] sadd(input logic signed [15:0] a, input logic signed [15:0] b);
    return sat16(20'(a) + 20'(b));
  endfunction
endpackage

// ===== logic/pre_filter.sv
// pre_filter: offset removal notch and pre-emphasis on each accepted sample
// assumes in_valid marks one sample per cycle at most, on the same clock
`timescale 1ns/10ps
module pre_filter
  import lpc_pkg::*;
(
  input logic clk,
  input logic arst_n,
  input logic in_valid,
  input pcm_t in_pcm,
  output logic out_valid,
  output logic signed [15:0] out_s
);
  logic signed [15:0] so_prev_ff, nxt_so_prev, sof_prev_ff, nxt_sof_prev, s_ff, nxt_s;
  logic v_ff, nxt_v;
  logic signed [15:0] so;

  always_comb
  begin
    so = {in_pcm.value, 3'h0};
    nxt_so_prev = so_prev_ff;
    nxt_sof_prev = sof_prev_ff;
    nxt_s = s_ff;
    nxt_v = in_valid;
    if (in_valid)
    begin
      nxt_sof_prev = sat16(20'(so) - 20'(so_prev_ff) + 20'(mulr(sof_prev_ff, $signed(ALPHA_Q15))));
      nxt_s = sat16(20'(nxt_sof_prev) - 20'(mulr(sof_prev_ff, $signed(BETA_Q15))));
      nxt_so_prev = so;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      so_prev_ff <= '0;
      sof_prev_ff <= '0;
      s_ff <= '0;
      v_ff <= 1'b0;
    end
    else
    begin
      so_prev_ff <= nxt_so_prev;
      sof_prev_ff <= nxt_sof_prev;
      s_ff <= nxt_s;
      v_ff <= nxt_v;
    end
  end

  assign out_valid = v_ff;
  assign out_s = s_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  notch_dc_a: assert property (@(posedge clk) disable iff (!arst_n)
    in_valid && {in_pcm.value, 3'h0} == so_prev_ff && sof_prev_ff == '0 |=> sof_prev_ff == '0)
    else $error("notch lets a constant input through");
  emph_a: assert property (@(posedge clk) disable iff (!arst_n)
    in_valid ##1 $past(sof_prev_ff) == '0 |-> out_s == sof_prev_ff)
    else $error("pre-emphasis output differs from offset-free input");
endmodule

// ===== logic/lpc_front_end.sv
// lpc_front_end: frame store, autocorrelation, recursion, area ratio coding,
// decoding and interpolated coefficient feed of a speech encoder front end
// assumes source and feed consumer run on clk and hold their handshakes
`timescale 1ns/10ps
module lpc_front_end
  import lpc_pkg::*;
#(
  parameter int DELAY_LIMIT_CYC = DELAY_MAX_MS * CLK_MHZ * 1000
)
(
  input logic clk,
  input logic arst_n,
  input logic in_valid,
  output logic in_ready,
  input pcm_t in_pcm,
  output logic feed_valid,
  input logic feed_ready,
  output feed_t feed,
  output logic code_valid,
  output logic [CODE_BITS-1:0] code_frame
);
  state_t state_ff, nxt_state;
  logic [7:0] idx_ff, nxt_idx, wr_idx_ff, jsel;
  logic [3:0] lag_ff, nxt_lag, n_ff, nxt_n, m_ff, nxt_m, dcnt_ff, nxt_dcnt;
  logic signed [47:0] acc_ff, nxt_acc, shifted;
  logic signed [47:0] acf_ff [NUM_LAGS];
  logic signed [47:0] nxt_acf [NUM_LAGS];
  logic signed [15:0] p_ff [NUM_LAGS];
  logic signed [15:0] nxt_p [NUM_LAGS];
  logic signed [15:0] q_ff [NUM_LAGS];
  logic signed [15:0] nxt_q [NUM_LAGS];
  logic signed [15:0] r_ff [ORDER];
  logic signed [15:0] nxt_r [ORDER];
  logic signed [17:0] dprev_ff [ORDER];
  logic signed [17:0] nxt_dprev [ORDER];
  logic signed [17:0] dcur_ff [ORDER];
  logic signed [17:0] nxt_dcur [ORDER];
  logic [15:0] quo_ff, nxt_quo;
  logic [16:0] rem_ff, nxt_rem, rem2, abs1;
  logic [CODE_BITS-1:0] frame_ff, nxt_frame;
  logic cvalid_ff, nxt_cvalid, accept, pre_v;
  feed_t feed_ff, nxt_feed, elem;
  logic signed [15:0] mem [FRAME_LEN];
  logic signed [15:0] pre_s, rc_cur;
  logic signed [31:0] prod;
  logic signed [7:0] code_w;
  logic [5:0] shift;
  logic [2:0] li;

  function automatic logic [1:0] seg_of(input logic [7:0] j);
    if (j < SEG1_START)
      return 2'h0;
    if (j < SEG2_START)
      return 2'h1;
    if (j < SEG3_START)
      return 2'h2;
    return 2'h3;
  endfunction

  function automatic logic signed [7:0] enc_lar(input logic signed [15:0] r, input logic [2:0] i);
    logic [16:0] ar;
    logic signed [17:0] alar;
    logic signed [34:0] z;
    logic [34:0] mag;
    logic signed [15:0] c;
    logic signed [15:0] cmax;
    ar = 17'(r[15] ? -17'(r) : 17'(r));
    // piecewise linear area ratio in Q13
    if (ar < 17'(RC_KNEE1))
      alar = 18'(ar >> 2);
    else if (ar < 17'(RC_KNEE2))
      alar = 18'(ar >> 1) - $signed(LAR_0675);
    else
      alar = 18'({ar, 1'b0}) - $signed(LAR_OFS2);
    if (r[15])
      alar = -alar;
    // scale, offset, round half away from zero
    z = ((35'($signed({1'b0, A_Q8[i]})) * 35'(alar)) >>> 8) + 35'(B_Q13[i]);
    mag = 35'(z[34] ? -z : z);
    mag = (mag + HALF_Q13) >> 13;
    c = z[34] ? -16'(mag) : 16'(mag);
    cmax = (16'sh0001 <<< (CODE_W[i] - 1)) - 16'sh0001;
    if (c > cmax)
      c = cmax;
    else if (c < -cmax - 16'sh0001)
      c = -cmax - 16'sh0001;
    return 8'(c);
  endfunction

  // inverse of the coding, reciprocal of A in Q16
  function automatic logic signed [17:0] dec_lar(input logic signed [7:0] c, input logic [2:0] i);
    logic signed [21:0] num;
    logic signed [39:0] pr;
    num = (22'(c) <<< 13) - 22'(B_Q13[i]);
    pr = 40'(num) * 40'($signed({1'b0, INV_A_Q16[i]}));
    return 18'(pr >>> 16);
  endfunction

  function automatic logic signed [15:0] lar_to_rc(input logic signed [17:0] p, input logic signed [17:0] c,
                                                   input logic [1:0] seg);
    logic signed [19:0] x;
    logic [19:0] ax;
    logic [19:0] m;
    case (seg)
      2'h0: x = ((20'(p) <<< 1) + 20'(p) + 20'(c)) >>> 2;
      2'h1: x = (20'(p) + 20'(c)) >>> 1;
      2'h2: x = (20'(p) + (20'(c) <<< 1) + 20'(c)) >>> 2;
      default: x = 20'(c);
    endcase
    ax = 20'(x[19] ? -x : x);
    if (ax > 20'(LAR_MAX))
      ax = 20'(LAR_MAX);
    if (ax < 20'(LAR_0675))
      m = ax << 2;
    else if (ax < 20'(LAR_KNEE2))
      m = (ax << 1) + 20'(RC_OFS1);
    else
      m = (ax >> 1) + 20'(RC_OFS2);
    if (m > 20'h07FFF)
      m = 20'h07FFF;
    return x[19] ? -16'(m) : 16'(m);
  endfunction

  // ----------------------------------------
  // sample path and frame store
  // ----------------------------------------
  assign in_ready = state_ff == S_COLLECT;
  assign accept = in_valid && in_ready;

  pre_filter u_pre (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(accept),
    .in_pcm(in_pcm),
    .out_valid(pre_v),
    .out_s(pre_s)
  );

  always_ff @(posedge clk)
  begin
    if (accept)
      wr_idx_ff <= idx_ff;
    if (pre_v)
      mem[wr_idx_ff] <= pre_s;
  end

  // ----------------------------------------
  // analysis sequencer
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_lag = lag_ff;
    nxt_n = n_ff;
    nxt_m = m_ff;
    nxt_dcnt = dcnt_ff;
    nxt_acc = acc_ff;
    nxt_acf = acf_ff;
    nxt_p = p_ff;
    nxt_q = q_ff;
    nxt_r = r_ff;
    nxt_dprev = dprev_ff;
    nxt_dcur = dcur_ff;
    nxt_quo = quo_ff;
    nxt_rem = rem_ff;
    nxt_frame = frame_ff;
    nxt_feed = feed_ff;
    nxt_cvalid = 1'b0;
    li = idx_ff[2:0];
    prod = 32'(mem[idx_ff]) * 32'(mem[8'(idx_ff - {4'h0, lag_ff})]);
    shift = '0;
    for (int b = 0; b < 46; b++)
      if (acf_ff[0][b])
        shift = 6'(45 - b);
    shifted = '0;
    abs1 = 17'(p_ff[1][15] ? -17'(p_ff[1]) : 17'(p_ff[1]));
    rem2 = {rem_ff[15:0], 1'b0};
    rc_cur = r_ff[3'(n_ff - 4'h1)];
    code_w = enc_lar(r_ff[li], li);
    jsel = (state_ff == S_PREP || idx_ff == LAST_IDX) ? 8'h00 : 8'(idx_ff + 8'h01);
    elem.index = jsel;
    elem.segment = seg_of(jsel);
    elem.sample = mem[jsel];
    for (int i = 0; i < ORDER; i++)
      elem.rc[i] = lar_to_rc(dprev_ff[i], dcur_ff[i], elem.segment);
    case (state_ff)
      S_COLLECT:
        if (accept)
        begin
          nxt_idx = idx_ff + 8'h01;
          if (idx_ff == LAST_IDX)
          begin
            nxt_idx = '0;
            nxt_lag = '0;
            nxt_acc = '0;
            nxt_state = S_ACF;
          end
        end
      S_ACF:
      begin
        nxt_acc = acc_ff + 48'(prod);
        nxt_idx = idx_ff + 8'h01;
        if (idx_ff == LAST_IDX)
        begin
          nxt_acf[lag_ff] = nxt_acc;
          nxt_acc = '0;
          nxt_lag = lag_ff + 4'h1;
          nxt_idx = {4'h0, nxt_lag};
          if (lag_ff == 4'h8)
            nxt_state = S_NORM;
        end
      end
      S_NORM:
      begin
        nxt_r = '{default: '0};
        nxt_idx = '0;
        nxt_n = 4'h1;
        nxt_state = (acf_ff[0] == '0) ? S_LAR : S_SCHUR;
        for (int i = 0; i < NUM_LAGS; i++)
        begin
          shifted = acf_ff[i] <<< shift;
          // leading one of lag 0 lands on bit 15, the sign bit: negative Q15 in [-1,0)
          nxt_p[i] = shifted[45:30];
          nxt_q[i] = shifted[45:30];
        end
      end
      S_SCHUR:
      begin
        nxt_rem = abs1;
        nxt_quo = '0;
        nxt_dcnt = '0;
        nxt_state = S_DIV;
        // unstable step leaves remaining coefficients at zero
        if ({1'b0, p_ff[0]} < abs1)
          nxt_state = S_LAR;
      end
      S_DIV:
      begin
        // magnitude below one by restoring division
        nxt_quo = {quo_ff[14:0], rem2 >= {1'b0, p_ff[0]}};
        nxt_rem = (rem2 >= {1'b0, p_ff[0]}) ? rem2 - {1'b0, p_ff[0]} : rem2;
        nxt_dcnt = dcnt_ff + 4'h1;
        if (dcnt_ff == 4'(DIV_STEPS - 1))
          nxt_state = S_RC;
      end
      S_RC:
      begin
        nxt_r[3'(n_ff - 4'h1)] = p_ff[1] > 16'sh0000 ? -$signed(quo_ff) : $signed(quo_ff);
        nxt_p[0] = sadd(p_ff[0], mulr(p_ff[1], nxt_r[3'(n_ff - 4'h1)]));
        nxt_m = 4'h1;
        nxt_state = (n_ff == 4'h8) ? S_LAR : S_UPD;
      end
      S_UPD:
      begin
        nxt_p[m_ff] = sadd(p_ff[m_ff + 4'h1], mulr(q_ff[m_ff], rc_cur));
        nxt_q[m_ff] = sadd(q_ff[m_ff], mulr(p_ff[m_ff + 4'h1], rc_cur));
        nxt_m = m_ff + 4'h1;
        if (m_ff == 4'h8 - n_ff)
        begin
          nxt_n = n_ff + 4'h1;
          nxt_state = S_SCHUR;
        end
      end
      S_LAR:
      begin
        // code bits placed LSB first at fixed positions
        for (int b = 0; b < 6; b++)
          if (b < CODE_W[li])
            nxt_frame[CODE_POS[li] + b] = code_w[b];
        nxt_dprev[li] = dcur_ff[li];
        nxt_dcur[li] = dec_lar(code_w, li);
        nxt_idx = idx_ff + 8'h01;
        if (li == 3'h7)
        begin
          nxt_cvalid = 1'b1;
          nxt_state = S_PREP;
        end
      end
      S_PREP:
      begin
        nxt_feed = elem;
        nxt_idx = '0;
        nxt_state = S_READ;
      end
      S_READ:
        // stored frame read out in order
        if (feed_ready)
        begin
          nxt_feed = elem;
          nxt_idx = idx_ff + 8'h01;
          if (idx_ff == LAST_IDX)
          begin
            nxt_idx = '0;
            nxt_state = S_COLLECT;
          end
        end
      default: nxt_state = S_COLLECT;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= S_COLLECT;
      idx_ff <= '0;
      lag_ff <= '0;
      n_ff <= '0;
      m_ff <= '0;
      dcnt_ff <= '0;
      acc_ff <= '0;
      acf_ff <= '{default: '0};
      p_ff <= '{default: '0};
      q_ff <= '{default: '0};
      r_ff <= '{default: '0};
      dprev_ff <= '{default: '0};
      dcur_ff <= '{default: '0};
      quo_ff <= '0;
      rem_ff <= '0;
      frame_ff <= '0;
      cvalid_ff <= 1'b0;
      feed_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      lag_ff <= nxt_lag;
      n_ff <= nxt_n;
      m_ff <= nxt_m;
      dcnt_ff <= nxt_dcnt;
      acc_ff <= nxt_acc;
      acf_ff <= nxt_acf;
      p_ff <= nxt_p;
      q_ff <= nxt_q;
      r_ff <= nxt_r;
      dprev_ff <= nxt_dprev;
      dcur_ff <= nxt_dcur;
      quo_ff <= nxt_quo;
      rem_ff <= nxt_rem;
      frame_ff <= nxt_frame;
      cvalid_ff <= nxt_cvalid;
      feed_ff <= nxt_feed;
    end
  end

  assign feed_valid = state_ff == S_READ;
  assign feed = feed_ff;
  assign code_valid = cvalid_ff;
  assign code_frame = frame_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [10:0] acf_cnt_ff;
  logic [31:0] dly_cnt_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acf_cnt_ff <= '0;
      dly_cnt_ff <= '0;
    end
    else
    begin
      acf_cnt_ff <= (state_ff == S_ACF) ? acf_cnt_ff + 11'h001 : 11'h000;
      dly_cnt_ff <= (state_ff == S_COLLECT || state_ff == S_READ) ? 32'h0 : dly_cnt_ff + 32'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  frame_len_a: assert property ($rose(state_ff == S_ACF) |-> $past(idx_ff) == LAST_IDX)
    else $error("frame did not hold 160 samples");
  acf_cycles_a: assert property (state_ff == S_ACF && nxt_state == S_NORM |-> acf_cnt_ff == 11'(ACF_CYCLES - 1))
    else $error("autocorrelation took the wrong number of products");
  div_steps_a: assert property ($rose(state_ff == S_DIV) |-> (state_ff == S_DIV) [*8] ##8 state_ff == S_RC)
    else $error("division did not take 15 steps");
  rc_bound_a: assert property (state_ff == S_RC |-> quo_ff <= 16'h7FFF)
    else $error("reflection magnitude above one");
  zero_code_a: assert property (state_ff == S_LAR && r_ff[li] == '0 && li < 3'h2 |-> code_w == '0)
    else $error("zero ratio did not code to zero");
  code_range_a: assert property (state_ff == S_LAR |->
    $signed(code_w) < (8'sh01 <<< (CODE_W[li] - 1)) && $signed(code_w) >= -(8'sh01 <<< (CODE_W[li] - 1)))
    else $error("code outside its clamp range");
  seg_map_a: assert property (feed_valid && feed.index >= SEG3_START |-> feed.segment == 2'h3)
    else $error("late samples not on current ratios");
  order_a: assert property ($rose(state_ff == S_READ) |-> $past(state_ff, 2) == S_LAR && $past(code_valid))
    else $error("readout started before parameters finished");
  rc_src_a: assert property (feed_valid && feed.segment == 2'h3 |->
    feed.rc[0] == lar_to_rc(dcur_ff[0], dcur_ff[0], 2'h3))
    else $error("fed coefficient not from decoded ratio");
  delay_a: assert property ($rose(state_ff == S_PREP) |-> dly_cnt_ff < 32'(DELAY_LIMIT_CYC))
    else $error("analysis exceeded the delay budget");

  frame_done_c: cover property (feed_valid && feed_ready && feed.index == LAST_IDX);
  early_stop_c: cover property (state_ff == S_SCHUR && nxt_state == S_LAR);
  clamp_c: cover property (state_ff == S_LAR && code_w == 8'h1F && li == 3'h0);
endmodule

// ===== tb/lpc_partner.sv
// lpc_partner: sample source and feed consumer beside the front end
// assumes go is raised per frame and dropped for one edge between frames
`timescale 1ns/10ps
module lpc_partner
  import lpc_pkg::*;
(
  input logic clk,
  input logic arst_n,
  input logic go,
  input logic impulse,
  input logic stall,
  input logic in_ready,
  output logic in_valid,
  output pcm_t in_pcm,
  output logic feed_ready
);
  logic [7:0] idx_ff;
  logic [1:0] ph_ff;

  function automatic pcm_t smp(input logic [7:0] i, input logic imp);
    pcm_t p;
    p.value = 13'h0000;
    if (imp && i == 8'h00)
      p.value = 13'h0FFF;
    if (imp && i == 8'h50)
      p.value = 13'h1060;
    return p;
  endfunction

  assign in_valid = go && idx_ff <= LAST_IDX;
  // released bus shows the inverse of the last sample
  assign in_pcm = in_valid ? smp(idx_ff, impulse) : pcm_t'(~smp(idx_ff - 8'h01, impulse));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx_ff <= 8'h00;
      ph_ff <= 2'h0;
      feed_ready <= 1'b0;
    end
    else
    begin
      ph_ff <= ph_ff + 2'h1;
      feed_ready <= !(stall && ph_ff != 2'h0);
      if (!go)
        idx_ff <= 8'h00;
      else if (in_valid && in_ready)
        idx_ff <= idx_ff + 8'h01;
    end
  end
endmodule

// ===== tb/lpc_front_end_bench.sv
// lpc_front_end_bench: self-checking bench of the speech front end
// assumes lpc_partner as source and consumer; expectations from real models
`timescale 1ns/10ps
module lpc_front_end_bench
  import lpc_pkg::*;
;
  localparam int DLY = 5000;
  localparam real A_R [ORDER] = '{20.0, 20.0, 20.0, 20.0, 13.637, 15.0, 8.334, 8.824};
  localparam real B_R [ORDER] = '{0.0, 0.0, 4.0, -5.0, 0.184, -3.5, -0.666, -2.235};
  localparam int LIM [ORDER] = '{32, 32, 16, 16, 8, 8, 4, 4};
  logic clk, arst_n, go, impulse, stall, in_valid, in_ready, feed_valid, feed_ready, code_valid;
  pcm_t in_pcm;
  feed_t feed;
  logic [CODE_BITS-1:0] code_frame, got_code, exp_code;
  feed_t got [FRAME_LEN];
  int errors, n_checks;
  real dec [ORDER];
  real s_mod [FRAME_LEN];

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  lpc_front_end #(.DELAY_LIMIT_CYC(DLY)) u_lpc_front_end (.clk(clk), .arst_n(arst_n), .in_valid(in_valid),
    .in_ready(in_ready), .in_pcm(in_pcm), .feed_valid(feed_valid), .feed_ready(feed_ready), .feed(feed),
    .code_valid(code_valid), .code_frame(code_frame));
  lpc_partner partner (.clk(clk), .arst_n(arst_n), .go(go), .impulse(impulse), .stall(stall),
    .in_ready(in_ready), .in_valid(in_valid), .in_pcm(in_pcm), .feed_ready(feed_ready));

  task automatic end_of_test();
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got_v, input logic [39:0] exp_v);
    n_checks++;
    if (got_v !== exp_v)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got_v, exp_v);
    end
  endtask

  task automatic chk_near(input logic signed [15:0] got_v, input real exp_v, input int tol);
    int e;
    e = $rtoi(exp_v);
    n_checks++;
    if ($isunknown(got_v) || got_v - e > tol || e - got_v > tol)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got_v, 16'(e));
    end
  endtask

  function automatic int nint(input real z);
    return z < 0.0 ? -$rtoi(-z + 0.5) : $rtoi(z + 0.5);
  endfunction

  // codes of a silent frame: zero ratios coded as B, clamped
  task automatic silent_codes();
    int i, c, pos;
    pos = 0;
    exp_code = '0;
    for (i = 0; i < ORDER; i++)
    begin
      c = nint(B_R[i]);
      c = c > LIM[i] - 1 ? LIM[i] - 1 : c < -LIM[i] ? -LIM[i] : c;
      dec[i] = (c - B_R[i]) / A_R[i];
      exp_code = exp_code | ((36'(c) & ((36'h1 << CODE_W[i]) - 36'h1)) << pos);
      pos += CODE_W[i];
    end
  endtask

  task automatic run_frame(input logic imp, input logic stl);
    int n, t;
    @(posedge clk);
    impulse <= imp;
    stall <= stl;
    go <= 1'b1;
    n = 0;
    for (t = 0; t < 400 && !(n > 0 && !in_ready); t++)
    begin
      @(negedge clk);
      if (in_valid && in_ready)
        n++;
    end
    chk(40'(n), 40'h0A0); // frame closes after 160 takes
    for (t = 0; t < DLY && code_valid !== 1'b1; t++)
    begin
      @(negedge clk);
      if (in_ready !== 1'b0 || feed_valid !== 1'b0)
        chk({in_ready, feed_valid}, 40'h0); // frame held during analysis
    end
    // codes within the delay budget
    if (t >= DLY)
    begin
      errors++;
      end_of_test();
    end
    got_code = code_frame;
    n = 0;
    for (t = 0; t < 2000 && n < FRAME_LEN; t++)
    begin
      @(negedge clk);
      if (in_ready !== 1'b0)
        chk(40'(in_ready), 40'h0); // no intake during readout
      if (feed_valid && feed_ready)
      begin
        got[n] = feed;
        n++;
      end
    end
    if (n < FRAME_LEN)
    begin
      errors++;
      end_of_test();
    end
    @(negedge clk);
    chk({feed_valid, in_ready}, 40'h1); // intake reopens after readout
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic check_feed(input logic hist, input logic imp);
    real sof, sofp, xp, x, s, f;
    int k, i, seg;
    sofp = 0.0;
    xp = 0.0;
    for (k = 0; k < FRAME_LEN; k++)
    begin
      seg = k < 13 ? 0 : k < 27 ? 1 : k < 40 ? 2 : 3;
      f = (hist || seg == 3) ? 1.0 : (seg + 1) * 0.25;
      chk(40'(got[k].index), 40'(k)); // words in index order
      chk(40'(got[k].segment), 40'(seg)); // segment by index
      x = !imp ? 0.0 : k == 0 ? 32760.0 : k == 80 ? -32000.0 : 0.0;
      sof = x - xp + 32735.0 / 32768.0 * sofp;
      s = sof - 28180.0 / 32768.0 * sofp;
      s = s > 32767.0 ? 32767.0 : s < -32768.0 ? -32768.0 : s;
      s_mod[k] = s;
      xp = x;
      sofp = sof;
      chk_near(got[k].sample, s, 64);
      for (i = 0; i < ORDER && !imp; i++)
        chk_near(got[k].rc[i], f * dec[i] * 32768.0, 32);
    end
  endtask

  // codes of the impulse frame from a real-valued analysis of the model samples, one step of slack
  task automatic impulse_codes();
    real acf [NUM_LAGS];
    real p [NUM_LAGS];
    real q [NUM_LAGS];
    real r, a, log_area_ratio, nx;
    int i, m, k, c, pos, halt;
    logic signed [15:0] g;
    for (i = 0; i < NUM_LAGS; i++)
    begin
      acf[i] = 0.0;
      for (k = i; k < FRAME_LEN; k++)
        acf[i] += s_mod[k] * s_mod[k - i];
      p[i] = acf[i];
      q[i] = acf[i];
    end
    pos = 0;
    halt = 0;
    for (i = 0; i < ORDER; i++)
    begin
      r = 0.0;
      halt = halt || p[0] <= 0.0 || p[0] < (p[1] < 0.0 ? -p[1] : p[1]);
      if (!halt)
      begin
        r = -p[1] / p[0];
        p[0] = p[0] + p[1] * r;
        for (m = 1; m < ORDER - i; m++)
        begin
          nx = p[m + 1];
          p[m] = nx + q[m] * r;
          q[m] = q[m] + nx * r;
        end
      end
      a = r < 0.0 ? -r : r;
      log_area_ratio = a < 0.675 ? a : a < 0.95 ? 2.0 * a - 0.675 : 8.0 * a - 6.375;
      c = nint(A_R[i] * (r < 0.0 ? -log_area_ratio : log_area_ratio) + B_R[i]);
      c = c > LIM[i] - 1 ? LIM[i] - 1 : c < -LIM[i] ? -LIM[i] : c;
      g = 16'(got_code >> pos) & 16'((1 << CODE_W[i]) - 1);
      if (g >= 16'(LIM[i]))
        g = g - 16'(2 * LIM[i]);
      chk_near(g, real'(c), 1);
      pos += CODE_W[i];
    end
  endtask

  task automatic sc_reset();
    @(negedge clk);
    chk({in_ready, feed_valid, code_valid, code_frame}, 40'h4000000000); // idle collect state
  endtask

  task automatic sc_silent_first();
    silent_codes();
    run_frame(1'b0, 1'b0);
    chk(40'(got_code), 40'(exp_code));
    check_feed(1'b0, 1'b0);
  endtask

  task automatic sc_silent_stall();
    run_frame(1'b0, 1'b1);
    chk(40'(got_code), 40'(exp_code));
    check_feed(1'b1, 1'b0);
  endtask

  task automatic sc_impulse();
    run_frame(1'b1, 1'b0);
    check_feed(1'b1, 1'b1);
    impulse_codes();
  endtask

  initial
  begin
    errors = 0;
    n_checks = 0;
    arst_n = 1'b0;
    go = 1'b0;
    impulse = 1'b0;
    stall = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    sc_reset();
    sc_silent_first();
    sc_silent_stall();
    sc_impulse();
    end_of_test();
  end
endmodule
